// [rtl/io_wake_irq_defs.svh]
// Register selects, field positions, writable masks and reset values
// Assumes inclusion by bare name from every design file that needs it
`ifndef IO_WAKE_IRQ_DEFS_SVH
`define IO_WAKE_IRQ_DEFS_SVH

// ****************************************************************
// Register selects
// ****************************************************************
`define SEL_IO_FLAGS 2'h0
`define SEL_IO_INHIBIT 2'h1
`define SEL_SUP_FLAGS 2'h2
`define SEL_SUP_INHIBIT 2'h3

// ****************************************************************
// Writable fields and reset values
// ****************************************************************
`define IO_IMPL_BITS 16'h01FB
`define IO_INPUT_BITS 16'h00FB
`define SUP_FLAG_BITS 16'h0BEF
`define SUP_INHIBIT_BITS 16'h03EF
`define REG_RESET 16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define IO_BIT_TIMER 8
`define SUP_BIT_MAIN_UV 0
`define SUP_BIT_MAIN_OV 1
`define SUP_BIT_DRV_UV 2
`define SUP_BIT_DRV_OV 3
`define SUP_BIT_SPI_REQ 5
`define SUP_BIT_SPI_CLK 6
`define SUP_BIT_SPI_CRC 7
`define SUP_BIT_I2C_REQ 8
`define SUP_BIT_I2C_CRC 9
`define SUP_BIT_BACKUP_UV 11
`define SUP_BIT_SWITCH 12

`endif

// [rtl/io_wake_irq_pkg.sv]
// Types shared by the interrupt flag and inhibit logic
// Assumes all registers are sixteen bits wide
package io_wake_irq_pkg;
    typedef logic [15:0] reg16_t;
    typedef logic [1:0] reg_sel_t;

    typedef struct packed {
        reg16_t bits;
    } bank_state_t;

    typedef struct packed {
        reg16_t rdata;
        logic rvalid;
        logic irq;
    } top_state_t;
endpackage : io_wake_irq_pkg

// [rtl/w1c_flag_bank.sv]
// Bank of sticky event flags, cleared by writing one
// Assumes set inputs are one-cycle or level events on the system clock
`timescale 1ns/1ns
`include "io_wake_irq_defs.svh"

module w1c_flag_bank #(
    parameter io_wake_irq_pkg::reg16_t IMPL = 16'hFFFF
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Events and clear
    input wire io_wake_irq_pkg::reg16_t i_set,
    input wire logic i_clr_wr,
    input wire io_wake_irq_pkg::reg16_t i_wdata,
    // Flags
    output io_wake_irq_pkg::reg16_t o_flags
);
    import io_wake_irq_pkg::*;

    bank_state_t s_q;
    bank_state_t s_d;
    reg16_t clr;

    always_comb begin
        clr = i_clr_wr ? i_wdata : `REG_RESET;
        s_d = s_q;
        s_d.bits = ((s_q.bits & ~clr) | i_set) & IMPL;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{bits: `REG_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_flags = s_q.bits;

    set_wins_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        |(i_set & IMPL) |=> ((o_flags & $past(i_set) & IMPL)
        == ($past(i_set) & IMPL)))
        else $error("flag event lost against a clear");
endmodule : w1c_flag_bank

// [rtl/inhibit_reg.sv]
// Read-write inhibit register with unimplemented bits held at zero
// Assumes one write strobe per access
`timescale 1ns/1ns
`include "io_wake_irq_defs.svh"

module inhibit_reg #(
    parameter io_wake_irq_pkg::reg16_t IMPL = 16'hFFFF
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Write access
    input wire logic i_wr,
    input wire io_wake_irq_pkg::reg16_t i_wdata,
    // Inhibit bits
    output io_wake_irq_pkg::reg16_t o_bits
);
    import io_wake_irq_pkg::*;

    bank_state_t s_q;
    bank_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_wr) begin
            s_d.bits = i_wdata & IMPL;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{bits: `REG_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_bits = s_q.bits;
endmodule : inhibit_reg

// [rtl/io_wake_and_supply_fault_irq.sv]
// Wake and I/O change flags, supply and link fault flags, their inhibit
// registers and the combined interrupt request.
// Assumes the serial front end gives a register select, read and write
// strobes and event pulses, all synchronous to i_sys_clk.
`timescale 1ns/1ns
`include "io_wake_irq_defs.svh"

module io_wake_and_supply_fault_irq (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register access
    input wire io_wake_irq_pkg::reg_sel_t i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire io_wake_irq_pkg::reg16_t i_reg_wdata,
    output io_wake_irq_pkg::reg16_t o_reg_rdata,
    output logic o_reg_rvalid,
    // Mode
    input wire logic i_normal_mode,
    // Input change and timer events
    input wire logic [6:0] i_io_change,
    input wire logic i_long_timer_evt,
    // Supply events
    input wire logic i_main_supply_uv,
    input wire logic i_main_supply_ov,
    input wire logic i_driver_supply_uv,
    input wire logic i_driver_supply_ov,
    input wire logic i_backup_supply_uv,
    input wire logic i_backup_switch_state,
    // Serial interface errors
    input wire logic i_spi_req_err,
    input wire logic i_spi_clk_err,
    input wire logic i_spi_crc_err,
    input wire logic i_i2c_req_err,
    input wire logic i_i2c_crc_err,
    // Interrupt request
    output logic o_irq
);
    import io_wake_irq_pkg::*;

    // ****************************************************************
    // Write decode
    // ****************************************************************
    logic wr_io_flags;
    logic wr_io_inhibit;
    logic wr_sup_flags;
    logic wr_sup_inhibit;

    assign wr_io_flags = i_reg_wr && (i_reg_sel == `SEL_IO_FLAGS);
    assign wr_io_inhibit = i_reg_wr && (i_reg_sel == `SEL_IO_INHIBIT);
    assign wr_sup_flags = i_reg_wr && (i_reg_sel == `SEL_SUP_FLAGS);
    assign wr_sup_inhibit = i_reg_wr && (i_reg_sel == `SEL_SUP_INHIBIT);

    // ****************************************************************
    // Event vectors
    // ****************************************************************
    reg16_t io_flags;
    reg16_t io_inhibit;
    reg16_t sup_flags;
    reg16_t sup_inhibit;
    reg16_t io_raw;
    reg16_t io_set;
    reg16_t sup_set;

    always_comb begin
        io_raw = `REG_RESET;
        io_raw[1:0] = i_io_change[1:0];
        io_raw[7:3] = i_io_change[6:2];
        io_raw[`IO_BIT_TIMER] = i_long_timer_evt;
        io_set = io_raw & ~(io_inhibit & `IO_INPUT_BITS);
    end

    always_comb begin
        sup_set = `REG_RESET;
        sup_set[`SUP_BIT_MAIN_UV] = i_main_supply_uv;
        sup_set[`SUP_BIT_MAIN_OV] = i_main_supply_ov;
        sup_set[`SUP_BIT_DRV_UV] = i_driver_supply_uv;
        sup_set[`SUP_BIT_DRV_OV] = i_driver_supply_ov;
        sup_set[`SUP_BIT_SPI_REQ] = i_spi_req_err;
        sup_set[`SUP_BIT_SPI_CLK] = i_spi_clk_err;
        sup_set[`SUP_BIT_SPI_CRC] = i_spi_crc_err;
        sup_set[`SUP_BIT_I2C_REQ] = i_i2c_req_err;
        sup_set[`SUP_BIT_I2C_CRC] = i_i2c_crc_err;
        sup_set[`SUP_BIT_BACKUP_UV] = i_backup_supply_uv;
    end

    // ****************************************************************
    // Flag and inhibit registers
    // ****************************************************************
    // clear by one, set wins, zero keeps
    w1c_flag_bank #(
        .IMPL(`IO_IMPL_BITS)
    ) u_io_flags (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_set(io_set),
        .i_clr_wr(wr_io_flags),
        .i_wdata(i_reg_wdata),
        .o_flags(io_flags)
    );

    w1c_flag_bank #(
        .IMPL(`SUP_FLAG_BITS)
    ) u_sup_flags (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_set(sup_set),
        .i_clr_wr(wr_sup_flags),
        .i_wdata(i_reg_wdata),
        .o_flags(sup_flags)
    );

    // reserved inhibit bits held at zero
    inhibit_reg #(
        .IMPL(`IO_IMPL_BITS)
    ) u_io_inhibit (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr(wr_io_inhibit),
        .i_wdata(i_reg_wdata),
        .o_bits(io_inhibit)
    );

    inhibit_reg #(
        .IMPL(`SUP_INHIBIT_BITS)
    ) u_sup_inhibit (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr(wr_sup_inhibit),
        .i_wdata(i_reg_wdata),
        .o_bits(sup_inhibit)
    );

    // ****************************************************************
    // Interrupt combine and read back
    // ****************************************************************
    logic io_pending;
    logic timer_pending;
    logic sup_pending;
    reg16_t sup_view;
    top_state_t s_q;
    top_state_t s_d;

    assign io_pending = |(io_flags & ~io_inhibit & `IO_INPUT_BITS)
        && i_normal_mode;
    assign timer_pending = io_flags[`IO_BIT_TIMER]
        && !io_inhibit[`IO_BIT_TIMER];
    assign sup_pending = |(sup_flags & ~sup_inhibit
        & `SUP_FLAG_BITS);

    always_comb begin
        sup_view = sup_flags & `SUP_FLAG_BITS;
        sup_view[`SUP_BIT_SWITCH] = i_backup_switch_state;
    end

    always_comb begin
        s_d = s_q;
        s_d.irq = io_pending || timer_pending || sup_pending;
        s_d.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            unique case (i_reg_sel)
                `SEL_IO_FLAGS: s_d.rdata = io_flags;
                `SEL_IO_INHIBIT: s_d.rdata = io_inhibit;
                `SEL_SUP_FLAGS: s_d.rdata = sup_view;
                `SEL_SUP_INHIBIT: s_d.rdata = sup_inhibit;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{rdata: `REG_RESET, rvalid: 1'b0, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_reg_rvalid = s_q.rvalid;
    assign o_irq = s_q.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    inhibit_write_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        wr_io_inhibit |=> io_inhibit == ($past(i_reg_wdata) & 16'h01FB))
        else $error("I/O inhibit write did not land in fields");

    io_irq_pass_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (|(io_flags & ~io_inhibit & 16'h00FB) && i_normal_mode) |=> o_irq)
        else $error("uninhibited input change gave no interrupt");

    io_irq_mode_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (!i_normal_mode && !timer_pending && !sup_pending) |=> !o_irq)
        else $error("input change interrupt outside Normal mode");

    timer_irq_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (io_flags[8] && !io_inhibit[8]) |=> o_irq)
        else $error("timer flag gave no interrupt");

    timer_inhibit_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (io_flags == 16'h0100 && io_inhibit[8] && sup_flags == 16'h0000)
        |=> !o_irq)
        else $error("inhibited timer flag raised interrupt");

    io_reserved_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        ((io_inhibit & ~16'h01FB) == 16'h0000)
        && ((io_flags & ~16'h01FB) == 16'h0000))
        else $error("reserved I/O bit set");

    w1c_clear_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (wr_sup_flags && i_reg_wdata[0] && !i_main_supply_uv)
        |=> !sup_flags[0])
        else $error("write one did not clear flag");

    main_uv_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_main_supply_uv |=> sup_flags[0])
        else $error("main supply under event not latched");

    main_ov_hold_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (sup_flags[1] && !(wr_sup_flags && i_reg_wdata[1]))
        |=> sup_flags[1])
        else $error("main supply over flag dropped");

    drv_supply_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (i_driver_supply_uv && i_driver_supply_ov)
        |=> (sup_flags[3:2] == 2'h3))
        else $error("driver supply flags not latched");

    spi_req_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_spi_req_err |=> sup_flags[5])
        else $error("SPI request error not latched");

    spi_clk_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_spi_clk_err |=> sup_flags[6])
        else $error("SPI clock error not latched");

    spi_crc_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_spi_crc_err |=> sup_flags[7])
        else $error("SPI CRC error not latched");

    i2c_req_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_i2c_req_err |=> sup_flags[8])
        else $error("I2C request error not latched");

    i2c_crc_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_i2c_crc_err |=> sup_flags[9])
        else $error("I2C CRC error not latched");

    backup_uv_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_backup_supply_uv |=> sup_flags[11])
        else $error("backup under event not latched");

    backup_clear_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (wr_sup_flags && i_reg_wdata[11] && !i_backup_supply_uv)
        |=> !sup_flags[11])
        else $error("write one did not clear backup under flag");

    switch_live_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (i_reg_rd && i_reg_sel == 2'h2)
        |=> o_reg_rdata[12] == $past(i_backup_switch_state))
        else $error("switch state read back wrong");

    sup_reserved_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        o_reg_rvalid && $past(i_reg_sel) == 2'h2
        |-> (o_reg_rdata & 16'hE410) == 16'h0000)
        else $error("reserved fault bit read nonzero");

    masked_input_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (i_io_change[0] && io_inhibit[0] && !io_flags[0]) |=> !io_flags[0])
        else $error("inhibited input change was recorded");

    sup_inhibit_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (sup_flags != 16'h0000 && (sup_flags & ~sup_inhibit) == 16'h0000
        && io_flags == 16'h0000) |=> !o_irq)
        else $error("inhibited fault flag raised interrupt");

    sup_irq_pass_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        ((sup_flags & ~sup_inhibit) != 16'h0000) |=> o_irq)
        else $error("uninhibited fault flag gave no interrupt");

    zero_keeps_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        wr_sup_flags |=> (($past(sup_flags) & ~$past(i_reg_wdata))
        & ~sup_flags) == 16'h0000)
        else $error("writing zero cleared a flag");

    irq_release_a: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (!io_pending && !timer_pending && !sup_pending) |=> !o_irq)
        else $error("interrupt held with nothing pending");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    irq_raise_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        !o_irq ##1 o_irq);

    clear_release_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        (wr_sup_flags && o_irq) ##2 !o_irq);

    set_and_clear_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        wr_sup_flags && i_reg_wdata[0] && i_main_supply_uv);

    timer_idle_mode_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        timer_pending && !i_normal_mode ##1 o_irq);
endmodule : io_wake_and_supply_fault_irq

// [tb/host_reg_model.sv]
// Host side register master for the wake and fault interrupt block
// Assumes the caller enters each task just after a falling clock edge
`timescale 1ns/1ns

module host_reg_model (
    // Clock
    input wire logic i_sys_clk,
    // Register requests to the device
    output io_wake_irq_pkg::reg_sel_t o_reg_sel,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output io_wake_irq_pkg::reg16_t o_reg_wdata,
    // Answers from the device
    input wire io_wake_irq_pkg::reg16_t i_reg_rdata,
    input wire logic i_reg_rvalid
);
    import io_wake_irq_pkg::*;

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    int idle_gap = 0;

    initial begin
        o_reg_sel = 2'h0;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    // Ones in data clear the matching latched flags when sel names a flag register
    task automatic write_reg(input reg_sel_t sel, input reg16_t data);
        o_reg_sel = sel;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        o_reg_wr = 1'b0;
        o_reg_sel = ~sel;
        o_reg_wdata = ~data;
        repeat (idle_gap + 1) @(negedge i_sys_clk);
    endtask : write_reg

    // Missing answer comes back as unknown data
    task automatic read_reg(input reg_sel_t sel, output reg16_t data);
        o_reg_sel = sel;
        o_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
        o_reg_rd = 1'b0;
        o_reg_sel = ~sel;
        repeat (idle_gap + 1) @(negedge i_sys_clk);
    endtask : read_reg
endmodule : host_reg_model

// [tb/io_wake_and_supply_fault_irq_tb.sv]
// Self-checking bench for the wake and supply fault interrupt block
// Assumes the host model drives the register port at falling edges
`timescale 1ns/1ns
`include "io_wake_irq_defs.svh"

module io_wake_and_supply_fault_irq_tb;
    import io_wake_irq_pkg::*;

    // ****************************************************************
    // Signals and event table
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic normal_mode = 1'b1;
    logic switch_state = 1'b0;
    logic [17:0] evt = 18'h0_0000;
    reg_sel_t reg_sel;
    logic reg_wr;
    logic reg_rd;
    logic rvalid;
    logic irq;
    reg16_t reg_wdata;
    reg16_t rdata;
    reg16_t rd_val;
    int err_total = 0;
    int total_checks = 0;
    reg_sel_t row_sel [18] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
    reg16_t row_bits [18] = '{
        16'h0001, 16'h0002, 16'h0008, 16'h0010, 16'h0020,
        16'h0040, 16'h0080, 16'h0100,
        16'h0001, 16'h0002,
        16'h0004, 16'h0008,
        16'h0800,
        16'h0020, 16'h0040, 16'h0080,
        16'h0100, 16'h0200};

    always #10 sys_clk = ~sys_clk;

    io_wake_and_supply_fault_irq io_wake_and_supply_fault_irq_inst (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_reg_sel(reg_sel),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_normal_mode(normal_mode), .i_io_change(evt[6:0]),
        .i_long_timer_evt(evt[7]), .i_main_supply_uv(evt[8]),
        .i_main_supply_ov(evt[9]), .i_driver_supply_uv(evt[10]),
        .i_driver_supply_ov(evt[11]), .i_backup_supply_uv(evt[12]),
        .i_backup_switch_state(switch_state), .i_spi_req_err(evt[13]),
        .i_spi_clk_err(evt[14]), .i_spi_crc_err(evt[15]),
        .i_i2c_req_err(evt[16]), .i_i2c_crc_err(evt[17]), .o_irq(irq));

    host_reg_model host_reg_model_inst (
        .i_sys_clk(sys_clk), .o_reg_sel(reg_sel), .o_reg_wr(reg_wr),
        .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid));

    // ****************************************************************
    // Compare and stimulus tasks
    // ****************************************************************
    task automatic chk_reg(input reg16_t got, input reg16_t exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: read %h, wanted %h", $time,
                got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic exp);
        total_checks++;
        if (irq !== exp) begin
            err_total++;
            $display("unexpected at %0t: irq %b, wanted %b", $time, irq, exp);
        end
    endtask : chk_irq

    task automatic chk_rvalid(input logic exp);
        total_checks++;
        if (rvalid !== exp) begin
            err_total++;
            $display("unexpected at %0t: rvalid %b, wanted %b", $time,
                rvalid, exp);
        end
    endtask : chk_rvalid

    task automatic rd_chk(input reg_sel_t sel, input reg16_t exp);
        host_reg_model_inst.read_reg(sel, rd_val);
        chk_reg(rd_val, exp);
    endtask : rd_chk

    task automatic wr(input reg_sel_t sel, input reg16_t data);
        host_reg_model_inst.write_reg(sel, data);
    endtask : wr

    task automatic pulse(input logic [17:0] v);
        evt = v;
        @(negedge sys_clk);
        evt = 18'h0_0000;
        @(negedge sys_clk);
    endtask : pulse

    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk_irq(1'b0);
        rd_chk(`SEL_IO_INHIBIT, 16'h0000);
        rd_chk(`SEL_SUP_FLAGS, 16'h0000);
        for (int k = 0; k < 18; k++) begin
            pulse(18'h0_0001 << k);
            chk_irq(1'b1);
            rd_chk(row_sel[k], row_bits[k]);
            wr(row_sel[k], row_bits[k]);
            chk_irq(1'b0);
            rd_chk(row_sel[k], 16'h0000);
        end
        // Inhibit layout and blocked inputs, slow host
        host_reg_model_inst.idle_gap = 3;
        wr(`SEL_IO_INHIBIT, 16'hFFFF);
        rd_chk(`SEL_IO_INHIBIT, 16'h01FB);
        host_reg_model_inst.idle_gap = 0;
        pulse(18'h0_007F);
        rd_chk(`SEL_IO_FLAGS, 16'h0000);
        chk_irq(1'b0);
        pulse(18'h0_0080);
        rd_chk(`SEL_IO_FLAGS, 16'h0100);
        chk_irq(1'b0);
        normal_mode = 1'b0;
        wr(`SEL_IO_INHIBIT, 16'h0000);
        @(negedge sys_clk);
        chk_irq(1'b1);
        wr(`SEL_IO_FLAGS, 16'h0100);
        pulse(18'h0_0001);
        rd_chk(`SEL_IO_FLAGS, 16'h0001);
        chk_irq(1'b0);
        normal_mode = 1'b1;
        @(negedge sys_clk);
        chk_irq(1'b1);
        wr(`SEL_IO_FLAGS, 16'hFFFF);
        // Write zero keeps flag, set wins over clear, live switch bit
        pulse(18'h0_0100);
        wr(`SEL_SUP_FLAGS, 16'h0000);
        rd_chk(`SEL_SUP_FLAGS, 16'h0001);
        evt = 18'h0_0100;
        wr(`SEL_SUP_FLAGS, 16'h0001);
        evt = 18'h0_0000;
        rd_chk(`SEL_SUP_FLAGS, 16'h0001);
        wr(`SEL_SUP_FLAGS, 16'hFFFF);
        switch_state = 1'b1;
        rd_chk(`SEL_SUP_FLAGS, 16'h1000);
        wr(`SEL_SUP_FLAGS, 16'h1000);
        rd_chk(`SEL_SUP_FLAGS, 16'h1000);
        chk_irq(1'b0);
        switch_state = 1'b0;
        rd_chk(`SEL_SUP_FLAGS, 16'h0000);
        // Fault inhibit: recorded but silent, backup flag always interrupts
        wr(`SEL_SUP_INHIBIT, 16'hFFFF);
        rd_chk(`SEL_SUP_INHIBIT, 16'h03EF);
        pulse(18'h3_EF00);
        rd_chk(`SEL_SUP_FLAGS, 16'h03EF);
        chk_irq(1'b0);
        pulse(18'h0_1000);
        chk_irq(1'b1);
        // Reset in mid-run clears everything
        wr(`SEL_IO_INHIBIT, 16'h01FB);
        rst = 1'b1;
        @(negedge sys_clk);
        chk_irq(1'b0);
        chk_rvalid(1'b0);
        rst = 1'b0;
        @(negedge sys_clk);
        rd_chk(`SEL_SUP_FLAGS, 16'h0000);
        rd_chk(`SEL_SUP_INHIBIT, 16'h0000);
        rd_chk(`SEL_IO_INHIBIT, 16'h0000);
        final_report();
    end
endmodule : io_wake_and_supply_fault_irq_tb
